// ===== led_engine_regs.vh
// Contract
// - ramp starts from current effective pwm
// - each step moves pwm one unit by sign
// - step duration from bit 14 and bits 13:9
// - prescale 0 divides engine clock by 16
// - prescale 1 divides engine clock by 512
// - step lasts step time times prescale cycle
// - run increment-count steps, up to 255
// - saturated ramp still runs full time
// - zero increments means pure wait
// - variable ramp latches operands at start
// - later variable writes do not affect ramp
// - a, b, c set only by load, add and subtract instructions
// - d is global, host writes 3C
// - conversion result may source variable d
// - only a readable locally; d read/write
// - log select bit picks log or linear
// - decode numeric branch, load, add, subtract
// - decode variable-count branch form
// - variable add/sub combine two variables
// - trigger holds wait and send fields
// - trigger don't-care bits are ignored
`ifndef LED_ENGINE_REGS_VH
`define LED_ENGINE_REGS_VH
`define GLOBAL_VAR_D_ADDR   8'h3C
`define CONV_RESULT_ADDR    8'h42
`define GLOBAL_VAR_D_RESET  8'h00
`define PRESCALE_BIT        14
`define STEP_TIME_MSB       13
`define STEP_TIME_LSB       9
`define SIGN_BIT            8
`define DIV_FAST_TICKS      9'h010
`define DIV_SLOW_TICKS      9'h200
`define PC_NEXT             2'h0
`define PC_START            2'h1
`define PC_GOTO             2'h2
`define PC_SKIP             2'h3
`endif

// ===== led_engine_ramp_branch_decoder.v
`timescale 1ns/10ps
`default_nettype none
`include "led_engine_regs.vh"
module led_engine_ramp_branch_decoder (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // engine clock pin, 32.7 kHz
  input  wire        eng_clk_i,
  // instruction issue
  input  wire [15:0] instr_i,
  input  wire        instr_valid_i,
  input  wire [7:0]  pwm_i,
  input  wire        log_en_i,
  // triggers
  input  wire [2:0]  eng_trig_i,
  input  wire        ext_trig_i,
  // register port of the serial bus
  input  wire [7:0]  reg_addr_i,
  input  wire        reg_wr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire [7:0]  conv_result_i,
  input  wire        d_src_conv_i,
  output reg  [7:0]  reg_rdata_o,
  // results
  output reg         busy_o,
  output reg         done_o,
  output reg  [1:0]  pc_cmd_o,
  output reg  [6:0]  pc_arg_o,
  output reg  [7:0]  pwm_o,
  output reg         pwm_we_o,
  output reg         log_ramp_o,
  output reg  [3:0]  trig_send_o,
  output reg         int_o,
  output reg         halt_o,
  output reg  [7:0]  var_a_o
);
  localparam S_IDLE = 2'h0;
  localparam S_RAMP = 2'h1;
  localparam S_TRIG = 2'h2;

  reg [1:0]  state_r;
  reg [2:0]  eclk_sync_r;
  reg [2:0]  ext_sync_r;
  reg [7:0]  var_b_r;
  reg [7:0]  var_c_r;
  reg [7:0]  var_d_r;
  reg [7:0]  loop_r;
  reg [8:0]  div_r;
  reg        pre_r;
  reg [4:0]  step_time_r;
  reg [4:0]  step_cnt_r;
  reg [7:0]  inc_r;
  reg [7:0]  left_r;
  reg        sign_r;
  reg [3:0]  pend_r;
  reg [3:0]  wait_mask_r;
  reg        eclk_lvl_r;
  reg        ext_lvl_r;

  // engine clock edge: counted once stages two and three agree on high
  wire eng_tick = eclk_sync_r[1] & eclk_sync_r[2] & ~eclk_lvl_r;
  // external trigger edge, same agreement rule as the engine clock
  wire ext_evt  = ext_sync_r[1] & ext_sync_r[2] & ~ext_lvl_r;
  wire [8:0] div_len = pre_r ? `DIV_SLOW_TICKS : `DIV_FAST_TICKS;
  wire base_tick = eng_tick && (div_r == div_len - 9'h001);
  wire step_end  = base_tick && (step_cnt_r == step_time_r - 5'h01);
  wire [7:0] var_d = d_src_conv_i ? conv_result_i : var_d_r;

  // variable select: 0 a, 1 b, 2 c, 3 d
  function [7:0] sel_var;
    input [1:0] s;
    input [7:0] a;
    input [7:0] b;
    input [7:0] c;
    input [7:0] d;
    begin
      case (s)
        2'h0: sel_var = a;
        2'h1: sel_var = b;
        2'h2: sel_var = c;
        default: sel_var = d;
      endcase
    end
  endfunction

  wire [7:0] v1 = sel_var(instr_i[3:2], var_a_o, var_b_r, var_c_r, var_d);
  wire [7:0] v2 = sel_var(instr_i[1:0], var_a_o, var_b_r, var_c_r, var_d);
  wire [7:0] vst = v1;
  wire [7:0] vinc = v2;

  // opcode classes
  wire is_rst    = (instr_i == 16'h0000);
  wire is_ramp_n = ~instr_i[15] &&
                   (instr_i[`STEP_TIME_MSB:`STEP_TIME_LSB] != 5'h00);
  wire is_ramp_v = (instr_i[15:6] == 10'h210);
  wire is_br_n   = (instr_i[15:13] == 3'h5);
  wire is_br_v   = (instr_i[15:9] == 7'h43);
  wire is_int    = (instr_i == 16'hC400);
  wire is_end    = (instr_i[15:13] == 3'h6) && (instr_i[10:0] == 11'h000);
  wire is_trig   = (instr_i[15:13] == 3'h7);
  wire is_jmp    = (instr_i[15:11] == 5'h11);
  wire is_data   = (instr_i[15:12] == 4'h9) && (instr_i[11:10] != 2'h3);

  // trigger fields, bits 11, 10, 5 and 4 never looked at
  wire [3:0] trig_wait = {instr_i[12], instr_i[9:7]};
  wire [3:0] trig_send = {instr_i[6], instr_i[3:1]};

  // conditional jump outcome
  reg jmp_take;
  always @* begin
    case (instr_i[10:9])
      2'h0: jmp_take = (v1 != v2);
      2'h1: jmp_take = (v1 < v2);
      2'h2: jmp_take = (v1 >= v2);
      default: jmp_take = (v1 == v2);
    endcase
  end

  // data result: load, add or subtract, immediate or two variables
  reg [7:0] data_res;
  always @* begin
    case (instr_i[9:8])
      2'h0: data_res = instr_i[7:0];
      2'h1: data_res = sel_var(instr_i[11:10], var_a_o, var_b_r,
                               var_c_r, var_d) + instr_i[7:0];
      2'h2: data_res = sel_var(instr_i[11:10], var_a_o, var_b_r,
                               var_c_r, var_d) - instr_i[7:0];
      default: data_res = instr_i[4] ? (v1 - v2) : (v1 + v2);
    endcase
  end

  // branch count: immediate or from a variable
  wire [7:0] br_cnt  = is_br_n ? {2'h0, instr_i[12:7]} : v2;
  wire [6:0] br_step = is_br_n ? instr_i[6:0] : instr_i[8:2];

  // synchronisers; the agreed level filters a one-sample glitch
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eclk_sync_r <= 3'h0;
      ext_sync_r  <= 3'h0;
      eclk_lvl_r  <= 1'b0;
      ext_lvl_r   <= 1'b0;
    end else begin
      eclk_sync_r <= {eclk_sync_r[1:0], eng_clk_i};
      ext_sync_r  <= {ext_sync_r[1:0], ext_trig_i};
      if (eclk_sync_r[1] == eclk_sync_r[2])
        eclk_lvl_r <= eclk_sync_r[2];
      if (ext_sync_r[1] == ext_sync_r[2])
        ext_lvl_r <= ext_sync_r[2];
    end
  end

  // host side of variable d and the read port
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      var_d_r     <= `GLOBAL_VAR_D_RESET;
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == `GLOBAL_VAR_D_ADDR)
        var_d_r <= reg_wdata_i;
      case (reg_addr_i)
        `GLOBAL_VAR_D_ADDR: reg_rdata_o <= var_d_r;
        `CONV_RESULT_ADDR:  reg_rdata_o <= conv_result_i;
        default:            reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // pending triggers: an arrival in the clearing cycle is kept
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r <= 4'h0;
    end else if (state_r == S_TRIG && (pend_r & wait_mask_r) == wait_mask_r)
    begin
      pend_r <= (pend_r & ~wait_mask_r) | {ext_evt, eng_trig_i};
    end else begin
      pend_r <= pend_r | {ext_evt, eng_trig_i};
    end
  end

  // execution
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r     <= S_IDLE;
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
      pc_cmd_o    <= `PC_NEXT;
      pc_arg_o    <= 7'h00;
      pwm_o       <= 8'h00;
      pwm_we_o    <= 1'b0;
      log_ramp_o  <= 1'b0;
      trig_send_o <= 4'h0;
      int_o       <= 1'b0;
      halt_o      <= 1'b0;
      var_a_o     <= 8'h00;
      var_b_r     <= 8'h00;
      var_c_r     <= 8'h00;
      loop_r      <= 8'h00;
      div_r       <= 9'h000;
      pre_r       <= 1'b0;
      step_time_r <= 5'h01;
      step_cnt_r  <= 5'h00;
      inc_r       <= 8'h00;
      left_r      <= 8'h00;
      sign_r      <= 1'b0;
      wait_mask_r <= 4'h0;
    end else begin
      done_o      <= 1'b0;
      pwm_we_o    <= 1'b0;
      trig_send_o <= 4'h0;
      int_o       <= 1'b0;
      halt_o      <= 1'b0;
      log_ramp_o  <= log_en_i;
      case (state_r)
        S_IDLE: begin
          pc_cmd_o <= `PC_NEXT;
          pc_arg_o <= 7'h00;
          if (instr_valid_i) begin
            busy_o <= 1'b1;
            done_o <= 1'b1;
            if (is_ramp_n || is_ramp_v) begin
              // operands captured now, so later writes cannot reach them
              done_o      <= 1'b0;
              state_r     <= S_RAMP;
              pwm_o       <= pwm_i;
              div_r       <= 9'h000;
              step_cnt_r  <= 5'h00;
              if (is_ramp_n) begin
                pre_r       <= instr_i[`PRESCALE_BIT];
                step_time_r <= instr_i[`STEP_TIME_MSB:`STEP_TIME_LSB];
                sign_r      <= instr_i[`SIGN_BIT];
                inc_r       <= instr_i[7:0];
                left_r      <= (instr_i[7:0] == 8'h00) ? 8'h01 : instr_i[7:0];
              end else begin
                pre_r       <= instr_i[5];
                // zero step time from a variable would wrap to 32 base ticks; run as one
                step_time_r <= (vst[4:0] == 5'h00) ? 5'h01 : vst[4:0];
                sign_r      <= instr_i[4];
                inc_r       <= vinc;
                left_r      <= (vinc == 8'h00) ? 8'h01 : vinc;
              end
            end else if (is_rst) begin
              pc_cmd_o <= `PC_START;
            end else if (is_br_n || is_br_v) begin
              // loop count zero loops for ever
              if (br_cnt == 8'h00) begin
                pc_cmd_o <= `PC_GOTO;
                pc_arg_o <= br_step;
              end else if (loop_r == 8'h00) begin
                loop_r   <= br_cnt;
                pc_cmd_o <= `PC_GOTO;
                pc_arg_o <= br_step;
              end else if (loop_r != 8'h01) begin
                loop_r   <= loop_r - 8'h01;
                pc_cmd_o <= `PC_GOTO;
                pc_arg_o <= br_step;
              end else begin
                loop_r <= 8'h00;
              end
            end else if (is_int) begin
              int_o <= 1'b1;
            end else if (is_end) begin
              halt_o <= 1'b1;
              int_o  <= instr_i[12];
              if (instr_i[11])
                pc_cmd_o <= `PC_START;
            end else if (is_trig) begin
              trig_send_o <= trig_send;
              wait_mask_r <= trig_wait;
              if (trig_wait != 4'h0) begin
                done_o  <= 1'b0;
                state_r <= S_TRIG;
              end
            end else if (is_jmp) begin
              if (jmp_take) begin
                pc_cmd_o <= `PC_SKIP;
                pc_arg_o <= {2'h0, instr_i[8:4]};
              end
            end else if (is_data) begin
              // only the engine's own load, add and subtract path writes a, b and c
              case (instr_i[11:10])
                2'h0: var_a_o <= data_res;
                2'h1: var_b_r <= data_res;
                default: var_c_r <= data_res;
              endcase
            end
          end else begin
            busy_o <= 1'b0;
          end
        end
        S_RAMP: begin
          if (eng_tick)
            div_r <= base_tick ? 9'h000 : div_r + 9'h001;
          if (base_tick)
            step_cnt_r <= step_end ? 5'h00 : step_cnt_r + 5'h01;
          if (step_end) begin
            // saturation only stops the value, never the timing
            if (inc_r != 8'h00) begin
              pwm_we_o <= 1'b1;
              if (!sign_r && pwm_o != 8'hFF)
                pwm_o <= pwm_o + 8'h01;
              else if (sign_r && pwm_o != 8'h00)
                pwm_o <= pwm_o - 8'h01;
            end
            left_r <= left_r - 8'h01;
            if (left_r == 8'h01) begin
              state_r <= S_IDLE;
              done_o  <= 1'b1;
            end
          end
        end
        S_TRIG: begin
          if ((pend_r & wait_mask_r) == wait_mask_r) begin
            state_r <= S_IDLE;
            done_o  <= 1'b1;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== led_engine_checker.sv
`timescale 1ns/10ps
`default_nettype none
module led_engine_checker (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // watched ports
  input wire logic [15:0] instr_i,
  input wire logic        instr_valid_i,
  input wire logic [7:0]  pwm_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  conv_result_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic [7:0]  pwm_o,
  input wire logic        pwm_we_o,
  input wire logic [3:0]  trig_send_o,
  input wire logic        int_o,
  input wire logic [7:0]  var_a_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // a word is taken in idle or in the done cycle
  wire go = instr_valid_i && (!busy_o || done_o);
  load_value_a: assert property (go && instr_i[15:8] == 8'h90 |=>
    done_o && var_a_o == $past(instr_i[7:0])) else $error("load value");
  add_value_a: assert property (go && instr_i[15:8] == 8'h91 |=>
    var_a_o == $past(var_a_o) + $past(instr_i[7:0])) else $error("add value");
  ramp_start_a: assert property (go && !instr_i[15] &&
    instr_i[13:9] != 5'h00 && instr_i[7:0] != 8'h00
    |=> busy_o && pwm_o == $past(pwm_i)) else $error("ramp start value");
  // a saturated step may repeat the end value, nothing else may jump
  step_size_a: assert property (pwm_we_o |->
    8'(pwm_o - $past(pwm_o)) inside {8'h01, 8'hFF} || (pwm_o == $past(pwm_o)
    && pwm_o inside {8'h00, 8'hFF})) else $error("ramp step size");
  int_instr_a: assert property (go && instr_i == 16'hC400 |=>
    int_o && done_o) else $error("interrupt word");
  trig_send_a: assert property (go && instr_i[15:13] == 3'h7 &&
    (instr_i & 16'h1380) == 16'h0000 |=> trig_send_o ==
    {$past(instr_i[6]), $past(instr_i[3:1])}) else $error("trigger send");
  conv_read_a: assert property (reg_addr_i == 8'h42 |=>
    reg_rdata_o == $past(conv_result_i)) else $error("conversion read");
  unmapped_read_a: assert property (reg_addr_i != 8'h3C &&
    reg_addr_i != 8'h42 |=> reg_rdata_o == 8'h00) else $error("unmapped read");
  cover property (go && !instr_i[15]);
  cover property (pwm_we_o);
  cover property (int_o);
endmodule
bind led_engine_ramp_branch_decoder led_engine_checker u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
  .instr_valid_i(instr_valid_i), .pwm_i(pwm_i), .reg_addr_i(reg_addr_i),
  .conv_result_i(conv_result_i), .reg_rdata_o(reg_rdata_o),
  .busy_o(busy_o), .done_o(done_o), .pwm_o(pwm_o), .pwm_we_o(pwm_we_o),
  .trig_send_o(trig_send_o), .int_o(int_o), .var_a_o(var_a_o));
`default_nettype wire

// ===== serial_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  // clock
  input  wire logic       clk_i,
  // register port
  output var  logic [7:0] reg_addr_o,
  output var  logic       reg_wr_o,
  output var  logic [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  // park on an unmapped address so a stale read never looks valid
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wr_o <= 1'b1;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
  endtask
  // read data follows the address by one edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    @(posedge clk_i);
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "led_engine_regs.vh"
module tb_top;
  logic clk_i, rst_n_i, eng_clk_i, instr_valid_i, log_en_i, ext_trig_i;
  logic d_src_conv_i;
  logic [15:0] instr_i;
  logic [7:0] pwm_i, conv_result_i, rd_val;
  logic [2:0] eng_trig_i;
  logic [3:0] snd;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata_o, pwm_o, var_a_o;
  wire logic reg_wr, busy_o, done_o, pwm_we_o, log_ramp_o, int_o, halt_o;
  wire logic [1:0] pc_cmd_o;
  wire logic [6:0] pc_arg_o;
  wire logic [3:0] trig_send_o;
  int error_cnt, checks_done, ticks, wes, k;
  led_engine_ramp_branch_decoder u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .eng_clk_i(eng_clk_i),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i), .pwm_i(pwm_i),
    .log_en_i(log_en_i), .eng_trig_i(eng_trig_i), .ext_trig_i(ext_trig_i),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata),
    .conv_result_i(conv_result_i), .d_src_conv_i(d_src_conv_i),
    .reg_rdata_o(reg_rdata_o), .busy_o(busy_o), .done_o(done_o),
    .pc_cmd_o(pc_cmd_o), .pc_arg_o(pc_arg_o), .pwm_o(pwm_o),
    .pwm_we_o(pwm_we_o), .log_ramp_o(log_ramp_o), .int_o(int_o),
    .trig_send_o(trig_send_o), .halt_o(halt_o), .var_a_o(var_a_o));
  serial_host_model u_host (.clk_i(clk_i), .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata_o));
  // 40 MHz system clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // engine clock runs only while waiting, so every tick lands after issue
  task automatic exec(input logic [15:0] w, input int bound);
    @(posedge clk_i);
    instr_i <= w;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    ticks = 0;
    wes = 0;
    snd = 4'h0;
    for (k = 0; k < bound; k++) begin
      @(negedge clk_i);
      wes += (pwm_we_o === 1'b1);
      if (trig_send_o !== 4'h0) snd = trig_send_o;
      if (done_o === 1'b1) break;
      @(posedge clk_i);
      if (k % 4 == 3) begin
        ticks += !eng_clk_i;
        eng_clk_i <= !eng_clk_i;
      end
    end
    if (k == bound) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic ramp(input logic [15:0] w, input logic [7:0] p,
                      input int t, input int n, input logic [7:0] e);
    @(posedge clk_i);
    pwm_i <= p;
    exec(w, 40000);
    chk(ticks, t);
    chk(wes, n);
    chk(pwm_o, e);
  endtask
  initial begin
    rst_n_i = 1'b0;
    eng_clk_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    pwm_i = 8'h00;
    log_en_i = 1'b1;
    ext_trig_i = 1'b0;
    eng_trig_i = 3'h0;
    conv_result_i = 8'h01;
    d_src_conv_i = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    u_host.rd(8'h3C, rd_val);
    chk(rd_val, `GLOBAL_VAR_D_RESET);
    u_host.wr(8'h3C, 8'h55);
    u_host.rd(8'h3C, rd_val);
    chk(rd_val, 8'h55);
    u_host.rd(8'h42, rd_val);
    chk(rd_val, 8'h01);
    u_host.rd(8'h10, rd_val);
    chk(rd_val, 8'h00);
    chk(log_ramp_o, 1'b1);
    $display("register test done");
    exec(16'h9012, 8);
    chk(var_a_o, 8'h12);
    exec(16'h9105, 8);
    chk(var_a_o, 8'h17);
    exec(16'h9203, 8);
    chk(var_a_o, 8'h14);
    exec(16'h9303, 8);
    chk(var_a_o, 8'h15);
    $display("data test done");
    ramp(16'h0202, 8'hFE, 32, 2, 8'hFF);
    ramp(16'h4201, 8'h80, 512, 1, 8'h81);
    ramp(16'h3E01, 8'h10, 496, 1, 8'h11);
    ramp(16'h0400, 8'h40, 32, 0, 8'h40);
    ramp(16'h0303, 8'h01, 48, 3, 8'h00);
    ramp(16'h02FF, 8'h00, 4080, 255, 8'hFF);
    fork
      ramp(16'h8403, 8'h20, 336, 1, 8'h21);
      begin
        repeat (40) @(posedge clk_i);
        conv_result_i <= 8'h09;
      end
    join
    $display("ramp test done");
    exec(16'hA189, 8);
    chk(pc_cmd_o, `PC_GOTO);
    chk(pc_arg_o, 7'h09);
    // loop count from variable b, which is zero, so the jump always goes
    exec(16'h8655, 8);
    chk(pc_cmd_o, `PC_GOTO);
    chk(pc_arg_o, 7'h15);
    // a against a first, then a (15h) against d (09h, the conversion)
    for (int i = 0; i < 8; i++) begin
      exec(16'(16'h8850 | ((i & 3) << 9) | ((i >> 2) * 3)), 8);
      chk(pc_cmd_o, (i < 4 ? i[1] : !i[0]) ? `PC_SKIP : `PC_NEXT);
      chk(pc_arg_o, (i < 4 ? i[1] : !i[0]) ? 7'h05 : 7'h00);
    end
    exec(16'h0000, 8);
    chk(pc_cmd_o, `PC_START);
    exec(16'hC400, 8);
    chk(int_o, 1'b1);
    exec(16'hD800, 8);
    chk(pc_cmd_o, `PC_START);
    chk({halt_o, int_o}, 2'h3);
    exec(16'hEC34, 8);
    chk(snd, 4'h2);
    exec(16'hE004, 8);
    chk(snd, 4'h2);
    // wait on engine one and the external pin; the pin edge lands last
    fork
      exec(16'hF080, 200);
      begin
        repeat (30) @(posedge clk_i);
        eng_trig_i <= 3'h1;
        ext_trig_i <= 1'b1;
        @(posedge clk_i);
        eng_trig_i <= 3'h0;
        repeat (8) @(posedge clk_i);
        ext_trig_i <= 1'b0;
      end
    join
    chk(k > 30, 1'b1);
    // variable d now from the host register instead of the conversion
    @(posedge clk_i);
    d_src_conv_i <= 1'b0;
    log_en_i <= 1'b0;
    exec(16'h9303, 8);
    chk(var_a_o, 8'h6A);
    chk(log_ramp_o, 1'b0);
    $display("branch test done");
    complete_run();
  end
endmodule
`default_nettype wire
